/* File: hdl/amx_pkg.sv */
// Constants shared by the eight-line serial multiplexer register block.
// Assumes 16-bit registers addressed by even byte offsets on a word bus.
package amx_pkg;
  localparam int unsigned NLINES = 8;
  localparam logic [2:0] ADDR_CSR      = 3'h0;
  localparam logic [2:0] ADDR_RECEIVE_BUFFER_LPR = 3'h2; // shared_receive_param_addr
  localparam logic [2:0] ADDR_TCR      = 3'h4;
  localparam logic [2:0] ADDR_MSR_TDR  = 3'h6; // shared_transmit_modem_addr
  localparam int CSR_MAINT  = 3;
  localparam int CSR_CLR    = 4;
  localparam int CSR_MSE    = 5;
  localparam int CSR_RIE    = 6;
  localparam int CSR_SAE    = 12;
  localparam int CSR_TIE    = 14;
  localparam int LPR_LEN    = 3;
  localparam int LPR_STOP   = 5;
  localparam int LPR_PEN    = 6;
  localparam int LPR_PODD   = 7;
  localparam int LPR_SPEED  = 8;
  localparam int LPR_RCV_ON = 12;
  localparam int unsigned SILO_DEPTH  = 32;
  localparam int unsigned SILO_WIDTH  = 15;
  localparam logic [4:0]  ALARM_COUNT = 5'h10;
  localparam logic [1:0]  LEN_FIVE    = 2'h0;
  localparam logic [1:0]  STOP_ONE    = 2'h0;
  localparam logic [1:0]  STOP_HALF   = 2'h1;
  localparam logic [1:0]  STOP_TWO    = 2'h2;
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned SCAN_GAP_NS = 1900;
  localparam int unsigned SCAN_GAP_CYC = (SCAN_GAP_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [0:0] {
    SC_SEARCH = 1'b0,
    SC_OFFER  = 1'b1
  } amx_scan_t;
endpackage : amx_pkg

/* File: hdl/amx_mux.sv */
// Register block and silo of an eight-line asynchronous serial multiplexer.
// Assumes bit-level UARTs outside: they hand in received characters on the
// same clock and report transmit-buffer empty per line on unsynchronised pins.
// Functional notes
// - Write-only and unused control bits read zero
// - Shared address: read buffer, write parameters
// - Every receive buffer read pops the silo
// - Clear leaves buffer bits 0-14 alone
// - Parameters go to addressed line; clear loses them
// - Byte writes to line parameters ignored
// - Line bit enables scanner; line interrupt ANDed
// - High byte terminal ready; clear spares it
// - Modem word: ring low, carrier high
// - Transmit word: char low, break high
// - Unused high transmit bits forced zero
// - Bits 8-11 select each line's rate
// - Bit 12 switches receiver clock
// - Bits 4:3 set length; high bits zero
// - Stop one, two, or 1.5 at five
// - Parity enable and sense, never buffered
// - Parity failure sets buffer bit 12
// - Both enables clear: receiver never interrupts
// - Receive done while silo holds character
// - Receive enable alone interrupts on done
// - Alarm after sixteen entries, cleared by read
// - Sense bit zero even, one odd
// - Bit 15 valid; clear resets it
// - Scanner priority: line 7 highest
`timescale 1ns/1ps
`default_nettype none

module amx_fifo #(
  parameter int unsigned WIDTH = 15,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  assign push      = in_valid & in_ready & ~flush;
  assign pop       = out_valid & out_ready & ~flush;
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];

  always_comb begin
    cnt_d = cnt_q;
    if (flush) begin
      cnt_d = '0;
    end else if (push & ~pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop & ~push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q    <= '0;
      wr_q     <= '0;
      rd_q     <= '0;
      in_ready <= 1'b1;
    end else begin
      cnt_q    <= cnt_d;
      in_ready <= (cnt_d != (AW+1)'(DEPTH));
      if (flush) begin
        wr_q <= '0;
        rd_q <= '0;
      end else begin
        if (push) begin
          wr_q <= wr_q + 1'b1;
        end
        if (pop) begin
          rd_q <= rd_q + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule : amx_fifo

module amx_mux (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [2:0]  bus_addr,
  input  wire logic        bus_rd,
  input  wire logic        bus_wr,
  input  wire logic [1:0]  bus_be,
  input  wire logic [15:0] bus_wdata,
  output logic      [15:0] bus_rdata,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic [2:0]  rx_line,
  input  wire logic [7:0]  rx_char,
  input  wire logic        rx_parity,
  input  wire logic        rx_framing_err,
  input  wire logic        rx_overrun,
  input  wire logic [7:0]  tx_empty,
  output logic             tx_load,
  output logic      [2:0]  tx_load_line,
  output logic      [7:0]  tx_char,
  output logic             tx_parity_bit,
  input  wire logic [7:0]  ring_indicator,
  input  wire logic [7:0]  carrier_state,
  output logic      [7:0]  terminal_ready,
  output logic      [7:0]  line_break_bit,
  output logic             loopback,
  output logic      [31:0] line_speed,
  output logic      [15:0] line_len,
  output logic      [15:0] line_stop,
  output logic      [7:0]  line_par_en,
  output logic      [7:0]  line_par_odd,
  output logic      [7:0]  line_rcv_on,
  output logic             rcv_int,
  output logic             xmt_int
);
  logic [7:0]  empty_m_q, empty_s_q, ring_m_q, ring_s_q, carr_m_q, carr_s_q;
  logic        clear_q;
  logic        mse_q, rie_q, sae_q, tie_q, sa_q, receive_done_flag_q;
  logic [7:0]  tcr_lo_q;
  logic [4:0]  alarm_q;
  logic [4:0]  alarm_d;
  logic [2:0]  tline_q;
  logic [7:0]  gap_q;
  amx_pkg::amx_scan_t scan_q;
  logic [3:0]  spd_q  [8];
  logic [1:0]  len_q  [8];
  logic [1:0]  stop_q [8];
  logic        wr_csr, wr_lpr, wr_tcr, wr_tdr, rd_receive_buffer, push_ok, fifo_ready;
  logic        silo_valid;
  logic [14:0] silo_head;
  logic [14:0] rx_word;
  logic [7:0]  rx_mask, tx_mask, cand;
  logic [1:0]  rx_len, tx_len;
  logic [2:0]  pick;
  logic [15:0] csr_word;

  // Modem and transmit-empty leads come from pins, so they are synchronised.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      empty_m_q <= 8'h00;
      empty_s_q <= 8'h00;
      ring_m_q  <= 8'h00;
      ring_s_q  <= 8'h00;
      carr_m_q  <= 8'h00;
      carr_s_q  <= 8'h00;
    end else begin
      empty_m_q <= tx_empty;
      empty_s_q <= empty_m_q;
      ring_m_q  <= ring_indicator;
      ring_s_q  <= ring_m_q;
      carr_m_q  <= carrier_state;
      carr_s_q  <= carr_m_q;
    end
  end

  assign wr_csr  = bus_wr & (bus_addr == amx_pkg::ADDR_CSR);
  assign wr_lpr  = bus_wr & (bus_addr == amx_pkg::ADDR_RECEIVE_BUFFER_LPR) & (&bus_be);
  assign wr_tcr  = bus_wr & (bus_addr == amx_pkg::ADDR_TCR);
  assign wr_tdr  = bus_wr & (bus_addr == amx_pkg::ADDR_MSR_TDR);
  assign rd_receive_buffer = bus_rd & (bus_addr == amx_pkg::ADDR_RECEIVE_BUFFER_LPR);

  // Control bits; the clear bit is a one-cycle pulse and reads as zero.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clear_q  <= 1'b0;
      loopback <= 1'b0;
      mse_q    <= 1'b0;
      rie_q    <= 1'b0;
      sae_q    <= 1'b0;
      tie_q    <= 1'b0;
    end else begin
      clear_q <= wr_csr & bus_be[0] & bus_wdata[amx_pkg::CSR_CLR];
      if (clear_q) begin
        loopback <= 1'b0;
        mse_q    <= 1'b0;
        rie_q    <= 1'b0;
        sae_q    <= 1'b0;
        tie_q    <= 1'b0;
      end else if (wr_csr) begin
        if (bus_be[0]) begin
          loopback <= bus_wdata[amx_pkg::CSR_MAINT];
          mse_q    <= bus_wdata[amx_pkg::CSR_MSE];
          rie_q    <= bus_wdata[amx_pkg::CSR_RIE];
        end
        if (bus_be[1]) begin
          sae_q <= bus_wdata[amx_pkg::CSR_SAE];
          tie_q <= bus_wdata[amx_pkg::CSR_TIE];
        end
      end
    end
  end

  // Per-line parameters, reached through the line field of the written word.
  for (genvar g = 0; g < 8; g++) begin : g_line
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        spd_q[g]        <= 4'h0;
        len_q[g]        <= 2'h0;
        stop_q[g]       <= amx_pkg::STOP_ONE;
        line_par_en[g]  <= 1'b0;
        line_par_odd[g] <= 1'b0;
        line_rcv_on[g]  <= 1'b0;
      end else if (clear_q) begin
        spd_q[g]        <= 4'h0;
        len_q[g]        <= 2'h0;
        stop_q[g]       <= amx_pkg::STOP_ONE;
        line_par_en[g]  <= 1'b0;
        line_par_odd[g] <= 1'b0;
        line_rcv_on[g]  <= 1'b0;
      end else if (wr_lpr && bus_wdata[2:0] == 3'(g)) begin
        spd_q[g]        <= bus_wdata[amx_pkg::LPR_SPEED +: 4];
        len_q[g]        <= bus_wdata[amx_pkg::LPR_LEN +: 2];
        line_par_en[g]  <= bus_wdata[amx_pkg::LPR_PEN];
        line_par_odd[g] <= bus_wdata[amx_pkg::LPR_PODD];
        line_rcv_on[g]  <= bus_wdata[amx_pkg::LPR_RCV_ON];
        if (!bus_wdata[amx_pkg::LPR_STOP]) begin
          stop_q[g] <= amx_pkg::STOP_ONE;
        end else if (bus_wdata[amx_pkg::LPR_LEN +: 2] == amx_pkg::LEN_FIVE) begin
          stop_q[g] <= amx_pkg::STOP_HALF;
        end else begin
          stop_q[g] <= amx_pkg::STOP_TWO;
        end
      end
    end
    assign line_speed[4*g +: 4] = spd_q[g];
    assign line_len[2*g +: 2]   = len_q[g];
    assign line_stop[2*g +: 2]  = stop_q[g];
  end

  // Receive path: trim to length, check parity, then queue in arrival order.
  assign rx_len  = len_q[rx_line];
  assign rx_mask = 8'hff >> (2'h3 - rx_len);
  assign rx_word[7:0]   = rx_char & rx_mask;
  assign rx_word[10:8]  = rx_line;
  assign rx_word[11]    = 1'b0;
  assign rx_word[12]    = line_par_en[rx_line]
                          & ((^rx_word[7:0] ^ rx_parity) != line_par_odd[rx_line]);
  assign rx_word[13]    = rx_framing_err;
  assign rx_word[14]    = rx_overrun;
  // Characters on a line whose receiver is off are taken and discarded.
  assign push_ok  = rx_valid & fifo_ready & line_rcv_on[rx_line] & ~clear_q;
  assign rx_ready = fifo_ready;

  amx_fifo #(
    .WIDTH (amx_pkg::SILO_WIDTH),
    .DEPTH (amx_pkg::SILO_DEPTH)
  ) u_silo (
    .clock     (clock),
    .rst       (rst),
    .flush     (clear_q),
    .in_valid  (rx_valid & line_rcv_on[rx_line]),
    .in_ready  (fifo_ready),
    .in_data   (rx_word),
    .out_valid (silo_valid),
    .out_ready (rd_receive_buffer),
    .out_data  (silo_head)
  );

  // An entry arriving on the read cycle counts toward the next alarm.
  always_comb begin
    alarm_d = alarm_q;
    if (rd_receive_buffer | clear_q) begin
      alarm_d = 5'h00;
    end
    if (push_ok && alarm_d != amx_pkg::ALARM_COUNT) begin
      alarm_d = alarm_d + 5'h01;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      alarm_q <= 5'h00;
      sa_q    <= 1'b0;
      receive_done_flag_q <= 1'b0;
      rcv_int <= 1'b0;
    end else begin
      alarm_q <= alarm_d;
      if (alarm_d == amx_pkg::ALARM_COUNT && push_ok) begin
        sa_q <= 1'b1;
      end else if (rd_receive_buffer | clear_q) begin
        sa_q <= 1'b0;
      end
      receive_done_flag_q <= silo_valid & ~clear_q;
      rcv_int <= rie_q & (sae_q ? sa_q : receive_done_flag_q);
    end
  end

  // Scanner: offers the highest ready line and, once it is loaded, rests before searching on,
  // so a stale empty indication from the loaded line is not offered again.
  always_comb begin
    cand = tcr_lo_q & empty_s_q;
    pick = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (cand[i]) begin
        pick = 3'(i);
      end
    end
  end

  assign tx_len  = len_q[tline_q];
  assign tx_mask = 8'hff >> (2'h3 - tx_len);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scan_q        <= amx_pkg::SC_SEARCH;
      tline_q       <= 3'h0;
      gap_q         <= 8'h00;
      tx_load       <= 1'b0;
      tx_load_line  <= 3'h0;
      tx_char       <= 8'h00;
      tx_parity_bit <= 1'b0;
      xmt_int       <= 1'b0;
    end else begin
      tx_load <= 1'b0;
      xmt_int <= (scan_q == amx_pkg::SC_OFFER) & tie_q & tcr_lo_q[tline_q];
      if (clear_q) begin
        scan_q  <= amx_pkg::SC_SEARCH;
        tline_q <= 3'h0;
        gap_q   <= 8'h00;
      end else begin
        case (scan_q)
          amx_pkg::SC_SEARCH: begin
            if (gap_q != 8'h00) begin
              gap_q <= gap_q - 8'h01;
            end else if (mse_q && cand != 8'h00) begin
              tline_q <= pick;
              scan_q  <= amx_pkg::SC_OFFER;
            end
          end
          amx_pkg::SC_OFFER: begin
            if (wr_tdr && bus_be[0]) begin
              tx_load       <= 1'b1;
              tx_load_line  <= tline_q;
              tx_char       <= bus_wdata[7:0] & tx_mask;
              tx_parity_bit <= line_par_en[tline_q]
                               & (^(bus_wdata[7:0] & tx_mask) ^ line_par_odd[tline_q]);
              gap_q         <= 8'(amx_pkg::SCAN_GAP_CYC);
              scan_q        <= amx_pkg::SC_SEARCH;
            end else if (!tcr_lo_q[tline_q] || !mse_q) begin
              scan_q <= amx_pkg::SC_SEARCH;
            end
          end
          default: scan_q <= amx_pkg::SC_SEARCH;
        endcase
      end
    end
  end

  // Line enables, terminal ready and break bits.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tcr_lo_q       <= 8'h00;
      terminal_ready <= 8'h00;
      line_break_bit <= 8'h00;
    end else begin
      if (clear_q) begin
        tcr_lo_q <= 8'h00;
      end else if (wr_tcr && bus_be[0]) begin
        tcr_lo_q <= bus_wdata[7:0];
      end
      if (wr_tcr && bus_be[1]) begin
        terminal_ready <= bus_wdata[15:8];
      end
      if (clear_q) begin
        line_break_bit <= 8'h00;
      end else if (wr_tdr && bus_be[1]) begin
        line_break_bit <= bus_wdata[15:8];
      end
    end
  end

  always_comb begin
    csr_word = 16'h0000;
    csr_word[amx_pkg::CSR_MAINT] = loopback;
    csr_word[amx_pkg::CSR_MSE]   = mse_q;
    csr_word[amx_pkg::CSR_RIE]   = rie_q;
    csr_word[7]                  = receive_done_flag_q;
    csr_word[10:8]               = tline_q;
    csr_word[amx_pkg::CSR_SAE]   = sae_q;
    csr_word[13]                 = sa_q;
    csr_word[amx_pkg::CSR_TIE]   = tie_q;
    csr_word[15]                 = (scan_q == amx_pkg::SC_OFFER);
  end

  // Read data is captured on the read cycle, before the silo advances.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_rdata <= 16'h0000;
    end else if (bus_rd) begin
      if (bus_addr == amx_pkg::ADDR_CSR) begin
        bus_rdata <= csr_word;
      end else if (bus_addr == amx_pkg::ADDR_RECEIVE_BUFFER_LPR) begin
        bus_rdata <= {silo_valid, silo_head};
      end else if (bus_addr == amx_pkg::ADDR_TCR) begin
        bus_rdata <= {terminal_ready, tcr_lo_q};
      end else if (bus_addr == amx_pkg::ADDR_MSR_TDR) begin
        bus_rdata <= {carr_s_q, ring_s_q};
      end else begin
        bus_rdata <= 16'h0000;
      end
    end
  end
endmodule : amx_mux

`default_nettype wire

/* File: test/amx_mux_props.sv */
// Port-level checker for the multiplexer register block.
// Assumes one clock and the asynchronous reset acting as bus initialisation.
`timescale 1ns/1ps
`default_nettype none
module amx_mux_props (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [2:0]  bus_addr,
  input wire logic        bus_rd,
  input wire logic        bus_wr,
  input wire logic [1:0]  bus_be,
  input wire logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic        rx_valid,
  input wire logic        rx_ready,
  input wire logic        tx_load,
  input wire logic [2:0]  tx_load_line,
  input wire logic [7:0]  tx_char,
  input wire logic        tx_parity_bit,
  input wire logic [7:0]  terminal_ready,
  input wire logic [7:0]  line_break_bit,
  input wire logic        loopback,
  input wire logic [31:0] line_speed,
  input wire logic [15:0] line_len,
  input wire logic [15:0] line_stop,
  input wire logic [7:0]  line_par_en,
  input wire logic [7:0]  line_rcv_on,
  input wire logic        rcv_int
);
  logic [15:0] wd_q;
  logic        lpw;
  logic        clw;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // The written word is kept so that checks one edge later see what was written.
  always_ff @(posedge clock) begin
    wd_q <= bus_wdata;
  end
  assign lpw = bus_wr && bus_addr == amx_pkg::ADDR_RECEIVE_BUFFER_LPR;
  assign clw = bus_wr && bus_addr == amx_pkg::ADDR_CSR && bus_be == 2'h1 && bus_wdata[4];
  chk_speed_load: assert property (lpw && bus_be == 2'h3 |=>
    line_speed[4*wd_q[2:0] +: 4] == wd_q[11:8]) else $error("line speed not loaded");
  chk_rcv_on_load: assert property (lpw && bus_be == 2'h3 |=>
    line_rcv_on[wd_q[2:0]] == wd_q[12]) else $error("receiver switch not loaded");
  chk_param_byte_drop: assert property (lpw && bus_be != 2'h3 |=>
    $stable(line_speed) && $stable(line_len) && $stable(line_rcv_on))
    else $error("byte write changed parameters");
  chk_stop_code: assert property (lpw && bus_be == 2'h3 |=>
    line_stop[2*wd_q[2:0] +: 2] == (!wd_q[5] ? amx_pkg::STOP_ONE :
    (wd_q[4:3] == amx_pkg::LEN_FIVE ? amx_pkg::STOP_HALF : amx_pkg::STOP_TWO)))
    else $error("stop code wrong");
  chk_ready_write: assert property (bus_wr && bus_addr == amx_pkg::ADDR_TCR && bus_be[1] |=>
    terminal_ready == wd_q[15:8]) else $error("terminal ready not written");
  chk_break_write: assert property (bus_wr && bus_addr == amx_pkg::ADDR_MSR_TDR && bus_be[1] |=>
    line_break_bit == wd_q[15:8]) else $error("break bits not written");
  chk_clear_effect: assert property (clw |-> ##[2:3]
    (line_rcv_on == 8'h0 && line_break_bit == 8'h0 && !loopback)) else $error("clear missed");
  chk_clear_spares: assert property (clw |=> $stable(terminal_ready)[*3])
    else $error("clear touched terminal ready");
  chk_tx_mask: assert property (tx_load |->
    (tx_char >> (4'h5 + {2'h0, line_len[2*tx_load_line +: 2]})) == 8'h0)
    else $error("unused transmit bits set");
  chk_par_off: assert property (tx_load && !line_par_en[tx_load_line] |-> !tx_parity_bit)
    else $error("parity bit with parity off");
  chk_load_pulse: assert property (tx_load |=> !tx_load) else $error("load pulse too long");
  chk_odd_unmapped: assert property (bus_rd && bus_addr[0] |=> bus_rdata == 16'h0)
    else $error("unmapped read not zero");
  cover property (tx_load);
  cover property (rcv_int);
  cover property (rx_valid && !rx_ready);
endmodule : amx_mux_props
bind amx_mux amx_mux_props u_props (.clock(clock), .rst(rst), .bus_addr(bus_addr),
  .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_be(bus_be), .bus_wdata(bus_wdata),
  .bus_rdata(bus_rdata), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_load(tx_load),
  .tx_load_line(tx_load_line), .tx_char(tx_char), .tx_parity_bit(tx_parity_bit),
  .terminal_ready(terminal_ready), .line_break_bit(line_break_bit), .loopback(loopback),
  .line_speed(line_speed), .line_len(line_len), .line_stop(line_stop),
  .line_par_en(line_par_en), .line_rcv_on(line_rcv_on), .rcv_int(rcv_int));
`default_nettype wire

/* File: test/amx_line_side.sv */
// Far-side model: line receivers posting characters and transmit buffers.
// Assumes the bench posts characters as {parity, line, char} words.
`timescale 1ns/1ps
`default_nettype none
module amx_line_side #(
  parameter int DRAIN = 400
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        post,
  input  wire logic [11:0] post_word,
  input  wire logic        rx_ready,
  output logic             rx_valid,
  output logic [2:0]       rx_line,
  output logic [7:0]       rx_char,
  output logic             rx_parity,
  input  wire logic        tx_load,
  input  wire logic [2:0]  tx_load_line,
  output logic [7:0]       tx_empty
);
  logic [11:0] q[$];
  logic [11:0] last;
  int          cnt[8];
  // Idle data lines show the inverse of the last word so no stale match passes.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      q.delete();
      last = 12'h0;
      rx_valid <= 1'b0;
      {rx_parity, rx_line, rx_char} <= 12'hfff;
    end else begin
      if (rx_valid && rx_ready) begin
        last = q.pop_front();
      end
      if (post) begin
        q.push_back(post_word);
      end
      rx_valid <= q.size() != 0;
      {rx_parity, rx_line, rx_char} <= q.size() != 0 ? q[0] : ~last;
    end
  end
  // A loaded buffer stays busy for a whole character time.
  always @(posedge clock or posedge rst) begin
    for (int i = 0; i < 8; i++) begin
      if (rst) cnt[i] = 0;
      else if (tx_load && tx_load_line == i) cnt[i] = DRAIN;
      else if (cnt[i] > 0) cnt[i] = cnt[i] - 1;
      tx_empty[i] <= cnt[i] == 0;
    end
  end
endmodule : amx_line_side
`default_nettype wire

/* File: test/test_amx_mux.sv */
// Self-checking bench for the multiplexer register block and its silo.
// Assumes the line-side model stands behind the serial ports.
`timescale 1ns/1ps
`default_nettype none
module test_amx_mux;
  localparam logic [2:0] A_CS = amx_pkg::ADDR_CSR;
  localparam logic [2:0] A_RB = amx_pkg::ADDR_RECEIVE_BUFFER_LPR;
  localparam logic [2:0] A_TC = amx_pkg::ADDR_TCR;
  localparam logic [2:0] A_MS = amx_pkg::ADDR_MSR_TDR;
  logic clock, rst, bus_rd, bus_wr, rx_valid, rx_ready, rx_parity, tx_load, tx_parity_bit;
  logic loopback, rcv_int, xmt_int, post;
  logic [1:0]  bus_be;
  logic [2:0]  bus_addr, rx_line, tx_load_line;
  logic [7:0]  rx_char, tx_empty, tx_char, ring, carrier, terminal_ready, line_break_bit;
  logic [7:0]  line_par_en, line_par_odd, line_rcv_on;
  logic [11:0] post_word;
  logic [15:0] bus_wdata, bus_rdata, line_len, line_stop, v;
  logic [31:0] line_speed;
  int miscompares = 0;
  int samples_checked = 0;
  amx_mux uut (.clock(clock), .rst(rst), .bus_addr(bus_addr), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_line(rx_line), .rx_char(rx_char),
    .rx_parity(rx_parity), .rx_framing_err(1'b0), .rx_overrun(1'b0), .tx_empty(tx_empty),
    .tx_load(tx_load), .tx_load_line(tx_load_line), .tx_char(tx_char),
    .tx_parity_bit(tx_parity_bit), .ring_indicator(ring), .carrier_state(carrier),
    .terminal_ready(terminal_ready), .line_break_bit(line_break_bit), .loopback(loopback),
    .line_speed(line_speed), .line_len(line_len), .line_stop(line_stop),
    .line_par_en(line_par_en), .line_par_odd(line_par_odd), .line_rcv_on(line_rcv_on),
    .rcv_int(rcv_int), .xmt_int(xmt_int));
  amx_line_side side (.clock(clock), .rst(rst), .post(post), .post_word(post_word),
    .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_line(rx_line), .rx_char(rx_char),
    .rx_parity(rx_parity), .tx_load(tx_load), .tx_load_line(tx_load_line),
    .tx_empty(tx_empty));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Each strobe task lets one edge pass before raising its strobe, so calls in a
  // row never reassign a strobe in one time step and a clear gets its idle cycle.
  task automatic wr(input logic [2:0] a, input logic [1:0] be, input logic [15:0] d);
    @(negedge clock);
    {bus_addr, bus_be, bus_wdata, bus_wr} = {a, be, d, 1'b1};
    @(negedge clock);
    bus_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(negedge clock);
    {bus_addr, bus_rd} = {a, 1'b1};
    @(negedge clock);
    bus_rd = 1'b0;
    v = bus_rdata;
  endtask : rd
  task automatic rdc(input logic [2:0] a, input logic [15:0] e);
    rd(a);
    chk(v, e);
  endtask : rdc
  task automatic post_ch(input logic [2:0] ln, input logic [7:0] c, input logic p);
    @(negedge clock);
    {post, post_word} = {1'b1, p, ln, c};
    @(negedge clock);
    post = 1'b0;
  endtask : post_ch
  task automatic wait_rdy();
    for (int i = 0; i < 600; i++) begin
      rd(A_CS);
      if (v[15] === 1'b1) return;
    end
    miscompares++;
    summarize();
  endtask : wait_rdy
  task automatic catch_load(input logic [2:0] ln, input logic [7:0] c, input logic p);
    for (int i = 0; i < 4; i++) begin
      if (tx_load === 1'b1) begin
        chk({4'h0, tx_parity_bit, tx_load_line, tx_char}, {4'h0, p, ln, c});
        return;
      end
      @(negedge clock);
    end
    chk(16'h0, 16'h1);
  endtask : catch_load
  task automatic t_reset_csr();
    rdc(A_CS, 16'h0);
    rdc(A_TC, 16'h0);
    rd(A_RB);
    chk({15'h0, v[15]}, 16'h0);
    wr(A_CS, 2'h3, 16'hffef);
    rdc(A_CS, 16'h5068);
    chk({15'h0, loopback}, 16'h1);
    wr(A_CS, 2'h1, 16'h0010);
    repeat (3) @(negedge clock);
    rdc(A_CS, 16'h0);
  endtask : t_reset_csr
  task automatic t_params();
    wr(A_RB, 2'h3, 16'h1efb);
    wr(A_RB, 2'h3, 16'h1025);
    wr(A_RB, 2'h1, 16'h0f03);
    chk({4'h0, line_speed[15:12], line_len[7:6], line_stop[7:6], line_par_en[3],
      line_par_odd[3], line_rcv_on[3], 1'b0}, 16'h0eee);
    chk({11'h0, line_stop[11:10], line_len[11:10], line_rcv_on[5]}, 16'h0009);
  endtask : t_params
  task automatic t_receive();
    wr(A_CS, 2'h3, 16'h0060);
    post_ch(3'h3, 8'ha5, 1'b1);
    post_ch(3'h0, 8'h11, 1'b0);
    post_ch(3'h5, 8'hff, 1'b0);
    post_ch(3'h3, 8'ha5, 1'b0);
    repeat (10) @(negedge clock);
    rd(A_CS);
    chk({14'h0, rcv_int, v[7]}, 16'h3);
    rdc(A_RB, 16'h83a5);
    repeat (100) @(negedge clock);
    rdc(A_RB, 16'h851f);
    repeat (100) @(negedge clock);
    rdc(A_RB, 16'h93a5);
    repeat (100) @(negedge clock);
    rd(A_RB);
    chk({15'h0, v[15]}, 16'h0);
    repeat (4) @(negedge clock);
    chk({15'h0, rcv_int}, 16'h0);
  endtask : t_receive
  task automatic t_alarm_fill();
    wr(A_CS, 2'h3, 16'h1060);
    for (int i = 0; i < 33; i++) begin
      post_ch(3'h3, i[7:0], ~^i[7:0]);
      if (i == 14 || i == 15) begin
        repeat (6) @(negedge clock);
        rd(A_CS);
        chk({14'h0, rcv_int, v[13]}, i == 15 ? 16'h3 : 16'h0);
      end
    end
    repeat (20) @(negedge clock);
    chk({15'h0, rx_ready}, 16'h0);
    for (int i = 0; i < 33; i++) begin
      rdc(A_RB, {8'h83, i[7:0]});
      if (i == 0) begin
        rd(A_CS);
        chk({15'h0, v[13]}, 16'h0);
      end
      repeat (100) @(negedge clock);
    end
    wr(A_CS, 2'h3, 16'h0020);
    post_ch(3'h3, 8'h55, 1'b1);
    repeat (6) @(negedge clock);
    rd(A_CS);
    chk({14'h0, rcv_int, v[7]}, 16'h1);
    rdc(A_RB, 16'h8355);
  endtask : t_alarm_fill
  task automatic t_transmit();
    wr(A_RB, 2'h3, 16'h00c1);
    wr(A_TC, 2'h3, 16'h8182);
    rdc(A_TC, 16'h8182);
    wr(A_CS, 2'h3, 16'h4020);
    wait_rdy();
    rd(A_CS);
    chk({12'h0, xmt_int, v[10:8]}, 16'h000f);
    wr(A_MS, 2'h1, 16'h00ff);
    catch_load(3'h7, 8'h1f, 1'b0);
    wait_rdy();
    chk({13'h0, v[10:8]}, 16'h0001);
    wr(A_MS, 2'h1, 16'h0040);
    catch_load(3'h1, 8'h00, 1'b1);
    repeat (200) @(negedge clock);
    wr(A_MS, 2'h2, 16'h0200);
    chk({8'h0, line_break_bit}, 16'h0002);
    {ring, carrier} = 16'h5ac3;
    repeat (4) @(negedge clock);
    rdc(A_MS, 16'hc35a);
    wr(A_CS, 2'h1, 16'h0010);
    repeat (4) @(negedge clock);
    rdc(A_TC, 16'h8100);
    rdc(A_MS, 16'hc35a);
    chk({line_break_bit, line_rcv_on}, 16'h0);
    rdc(3'h1, 16'h0);
  endtask : t_transmit
  initial begin
    {rst, bus_rd, bus_wr, post, bus_addr, bus_be, bus_wdata, post_word} = {1'b1, 36'h0};
    {ring, carrier} = 16'h0;
    repeat (12) @(negedge clock);
    rst = 1'b0;
    t_reset_csr();
    t_params();
    t_receive();
    t_alarm_fill();
    t_transmit();
    summarize();
  end
endmodule : test_amx_mux
`default_nettype wire
